// [core/pin_state_pkg.sv]
// Purpose: shared constants for the peripheral pin state block
// Assumes: 10 MHz system clock, Avalon-MM byte addressing
// Notes: pin order matches the bit order of the pin state register
package pin_state_pkg;
   localparam int unsigned NUM_PINS = 22;
   localparam int unsigned NUM_OWNERS = 10;
   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] STATE_REG_OFFSET = 4'h0;
   localparam logic [31:0] RESERVED_READ = 32'h0000_0000;
   // field positions
   localparam int unsigned DATA_LSB = 0;
   localparam int unsigned DATA_MSB = 7;
   localparam int unsigned PIXEL_CLOCK_BIT = 8;
   localparam int unsigned LINE_CLOCK_BIT = 9;
   localparam int unsigned FRAME_CLOCK_BIT = 10;
   localparam int unsigned AC_BIAS_BIT = 11;
   localparam int unsigned P1_TX_BIT = 12;
   localparam int unsigned P1_RX_BIT = 13;
   localparam int unsigned P2_TX_BIT = 14;
   localparam int unsigned P2_RX_BIT = 15;
   localparam int unsigned P3_TX_BIT = 16;
   localparam int unsigned P3_RX_BIT = 17;
   localparam int unsigned P4_TX_BIT = 18;
   localparam int unsigned P4_RX_BIT = 19;
   localparam int unsigned P4_CLOCK_BIT = 20;
   localparam int unsigned P4_FRAME_BIT = 21;
   // owner function of each pin, index into the owner enable vector
   localparam int unsigned OWN_DISPLAY = 0;
   localparam int unsigned OWN_P1_TX = 1;
   localparam int unsigned OWN_P1_RX = 2;
   localparam int unsigned OWN_P2_TX = 3;
   localparam int unsigned OWN_P2_RX = 4;
   localparam int unsigned OWN_P3_TX = 5;
   localparam int unsigned OWN_P3_RX = 6;
   localparam int unsigned OWN_P4_TX = 7;
   localparam int unsigned OWN_P4_RX = 8;
   localparam int unsigned OWN_P4_PORT = 9;
   // sampler rate from a fractional accumulator
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned SAMPLE_HZ = 7_372_800;
   localparam int unsigned ACC_W = 24;
   localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(SAMPLE_HZ);
   localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_HZ);
   localparam logic [ACC_W-1:0] ACC_RESET = 24'h00_0000;
   typedef enum logic [0:0]
   {
      BUS_IDLE = 1'b0,
      BUS_ANSWER = 1'b1
   } bus_state_type;
endpackage

// [core/pin_sample_if.sv]
// Purpose: carries raw pin levels in and sampled levels out
// Assumes: one clock domain on the sampled side
// Notes: raw levels are asynchronous to the system clock
`timescale 1ns/1ns
`default_nettype none
interface pin_sample_if;
   logic [pin_state_pkg::NUM_PINS-1:0] raw;
   logic [pin_state_pkg::NUM_PINS-1:0] level;
   modport sampler (input raw, output level);
   modport user (output raw, input level);
endinterface
`default_nettype wire

// [core/pin_sampler.sv]
// Purpose: synchronise the pins and resample them at the sampler rate
// Assumes: pins are asynchronous to i_clk
// Notes: sampled levels are not reset, as the register holds no reset value
`timescale 1ns/1ns
`default_nettype none
module pin_sampler
(
   input wire logic i_clk,
   input wire logic i_rst,
   pin_sample_if.sampler pins
);
   import pin_state_pkg::*;

   logic [NUM_PINS-1:0] meta_r;
   logic [NUM_PINS-1:0] sync_r;
   logic [NUM_PINS-1:0] level_r;
   logic [NUM_PINS-1:0] level_nxt;
   logic [ACC_W-1:0] acc_r;
   logic [ACC_W-1:0] acc_nxt;
   logic tick_r;
   logic tick_nxt;
   logic [ACC_W:0] sum;

   ////////////////////////////////////////////////////////////////////////
   // fractional divider: tick averages 7.3728 MHz out of 10 MHz
   always_comb
   begin
      sum = {1'b0, acc_r} + {1'b0, ACC_STEP};
      if (sum >= {1'b0, ACC_MOD})
      begin
         acc_nxt = ACC_W'(sum - {1'b0, ACC_MOD});
         tick_nxt = 1'b1;
      end
      else
      begin
         acc_nxt = sum[ACC_W-1:0];
         tick_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         acc_r <= ACC_RESET;
         tick_r <= 1'b0;
      end
      else
      begin
         acc_r <= acc_nxt;
         tick_r <= tick_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // two flops, then resample on the tick
   always_comb
   begin
      level_nxt = tick_r ? sync_r : level_r;
   end

   always_ff @(posedge i_clk)
   begin
      meta_r <= pins.raw;
      sync_r <= meta_r;
      level_r <= level_nxt;
   end

   assign pins.level = level_r;
endmodule
`default_nettype wire

// [core/peripheral_pin_state_gpio.sv]
// Purpose: pin state register letting idle peripheral pins act as gpio
// Assumes: direction and peripheral enables come from i_clk logic
// Notes: one register, write side and read side are separate storage
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - bits 7:0 read back the eight display data pin levels
// - display data pins driven from written bits if display off and output
// - bit 8 reads pixel clock pin; drives it if display off and output
// - line clock bit reads pin; drives it if display off and output
// - frame clock bit reads pin; drives it if display off and output
// - ac bias bit reads pin; drives it if display off and output
// - port 1 transmit bit reads pin; drives if transmitter off and output
// - port 1 receive bit reads pin; drives if receiver off and output
// - port 2 transmit bit reads pin; drives if transmitter off and output
// - port 2 receive bit reads pin; drives if receiver off and output
// - port 3 transmit bit reads pin; drives if transmitter off and output
// - port 3 receive bit reads back the receive pin level
// - port 4 transmit bit reads pin; drives if transmitter off and output
// - a bit reports the port 4 clock pin level on read
// - writes store drive values; reads return pins resampled at 7.3728 MHz
// - register has no reset; reserved bits ignore writes, read zero
module peripheral_pin_state_gpio
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [pin_state_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic [pin_state_pkg::NUM_PINS-1:0] i_pin_dir_out,
   input wire logic i_display_enable,
   input wire logic i_port1_tx_enable,
   input wire logic i_port1_rx_enable,
   input wire logic i_port2_tx_enable,
   input wire logic i_port2_rx_enable,
   input wire logic i_port3_tx_enable,
   input wire logic i_port3_rx_enable,
   input wire logic i_port4_tx_enable,
   input wire logic i_port4_rx_enable,
   input wire logic i_port4_enable,
   input wire logic [pin_state_pkg::NUM_PINS-1:0] i_pin_in,
   output logic [pin_state_pkg::NUM_PINS-1:0] o_pin_out,
   output logic [pin_state_pkg::NUM_PINS-1:0] o_pin_oe_n
);
   import pin_state_pkg::*;

   pin_sample_if samp ();

   bus_state_type bus_r;
   bus_state_type bus_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [NUM_PINS-1:0] out_val_r;
   logic [NUM_PINS-1:0] out_val_nxt;
   logic [NUM_PINS-1:0] pin_out_r;
   logic [NUM_PINS-1:0] pin_out_nxt;
   logic [NUM_PINS-1:0] oe_n_r;
   logic [NUM_PINS-1:0] oe_n_nxt;
   logic [NUM_OWNERS-1:0] owner_en;
   logic [NUM_PINS-1:0] owned;
   logic [NUM_PINS-1:0] wmask;
   logic hit;
   logic req;
   logic wait_r;
   logic wait_nxt;

   ////////////////////////////////////////////////////////////////////////
   // input path: every pin level goes through the sampler
   assign samp.raw = i_pin_in;

   pin_sampler u_sampler
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .pins(samp.sampler)
   );

   ////////////////////////////////////////////////////////////////////////
   // owner of each pin; a pin is gpio only while its owner is off
   assign owner_en[OWN_DISPLAY] = i_display_enable;
   assign owner_en[OWN_P1_TX] = i_port1_tx_enable;
   assign owner_en[OWN_P1_RX] = i_port1_rx_enable;
   assign owner_en[OWN_P2_TX] = i_port2_tx_enable;
   assign owner_en[OWN_P2_RX] = i_port2_rx_enable;
   assign owner_en[OWN_P3_TX] = i_port3_tx_enable;
   assign owner_en[OWN_P3_RX] = i_port3_rx_enable;
   assign owner_en[OWN_P4_TX] = i_port4_tx_enable;
   assign owner_en[OWN_P4_RX] = i_port4_rx_enable;
   assign owner_en[OWN_P4_PORT] = i_port4_enable;

   function automatic int unsigned owner_of(input int unsigned pin);
      int unsigned own;
      own = OWN_P4_PORT;
      if (pin <= DATA_MSB || pin == PIXEL_CLOCK_BIT)
         own = OWN_DISPLAY;
      else if (pin == LINE_CLOCK_BIT || pin == FRAME_CLOCK_BIT)
         own = OWN_DISPLAY;
      else if (pin == AC_BIAS_BIT)
         own = OWN_DISPLAY;
      else if (pin == P1_TX_BIT)
         own = OWN_P1_TX;
      else if (pin == P1_RX_BIT)
         own = OWN_P1_RX;
      else if (pin == P2_TX_BIT)
         own = OWN_P2_TX;
      else if (pin == P2_RX_BIT)
         own = OWN_P2_RX;
      else if (pin == P3_TX_BIT)
         own = OWN_P3_TX;
      else if (pin == P3_RX_BIT)
         own = OWN_P3_RX;
      else if (pin == P4_TX_BIT)
         own = OWN_P4_TX;
      else if (pin == P4_RX_BIT)
         own = OWN_P4_RX;
      return own;
   endfunction

   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++)
      begin : g_pin
         assign owned[g] = owner_en[owner_of(g)];
         assign wmask[g] = i_avs_byteenable[g / 8];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // avalon slave: waitrequest drops one cycle after a request appears
   assign req = i_avs_read | i_avs_write;
   assign hit = (i_avs_address == STATE_REG_OFFSET);

   always_comb
   begin
      bus_nxt = BUS_IDLE;
      rdata_nxt = rdata_r;
      unique case (bus_r)
         BUS_IDLE:
         begin
            if (req)
            begin
               bus_nxt = BUS_ANSWER;
               // read data is built here so it stands with waitrequest low
               rdata_nxt = RESERVED_READ;
               if (hit && i_avs_read)
               begin
                  rdata_nxt[NUM_PINS-1:0] = samp.level;
               end
            end
         end
         BUS_ANSWER:
         begin
            bus_nxt = BUS_IDLE;
         end
      endcase
      // registered so the bus sees waitrequest straight from a flop
      wait_nxt = (bus_nxt == BUS_IDLE);
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         bus_r <= BUS_IDLE;
         rdata_r <= RESERVED_READ;
         wait_r <= 1'b1;
      end
      else
      begin
         bus_r <= bus_nxt;
         rdata_r <= rdata_nxt;
         wait_r <= wait_nxt;
      end
   end

   assign o_avs_readdata = rdata_r;
   assign o_avs_waitrequest = wait_r;

   ////////////////////////////////////////////////////////////////////////
   // write side storage, not reset; bits 31:22 have no storage at all
   always_comb
   begin
      out_val_nxt = out_val_r;
      if (bus_r == BUS_ANSWER && i_avs_write && hit)
      begin
         out_val_nxt = (out_val_r & ~wmask) |
            (i_avs_writedata[NUM_PINS-1:0] & wmask);
      end
   end

   always_ff @(posedge i_clk)
   begin
      out_val_r <= out_val_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // pin drivers: stored value reaches a pin only while it is gpio output
   // port 2 polarity is left to software, so the pin is driven as written
   always_comb
   begin
      oe_n_nxt = ~(i_pin_dir_out & ~owned);
      pin_out_nxt = out_val_nxt & ~oe_n_nxt;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         oe_n_r <= '1;
         pin_out_r <= '0;
      end
      else
      begin
         oe_n_r <= oe_n_nxt;
         pin_out_r <= pin_out_nxt;
      end
   end

   assign o_pin_oe_n = oe_n_r;
   assign o_pin_out = pin_out_r;
endmodule
`default_nettype wire

// [bench/pin_partner.sv]
// Purpose: outside drivers on the shared pins
// Assumes: a source holds every pin the block leaves free
// Notes: block wins where it drives, no contention
`timescale 1ns/1ns
`default_nettype none
module pin_partner
(
   input wire logic [pin_state_pkg::NUM_PINS-1:0] i_drv,
   input wire logic [pin_state_pkg::NUM_PINS-1:0] i_oe_n,
   input wire logic [pin_state_pkg::NUM_PINS-1:0] i_ext,
   output logic [pin_state_pkg::NUM_PINS-1:0] o_level
);
   import pin_state_pkg::*;
   assign o_level = (i_drv & ~i_oe_n) | (i_ext & i_oe_n);
endmodule
`default_nettype wire

// [bench/peripheral_pin_state_gpio_assertions.sv]
// Purpose: port checks for the pin state block
// Assumes: one clock, async active high reset
// Notes: attached by bind below
`timescale 1ns/1ns
`default_nettype none
module pin_state_checker
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [pin_state_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic [pin_state_pkg::NUM_PINS-1:0] i_pin_dir_out,
   input wire logic i_display_enable,
   input wire logic i_port1_tx_enable,
   input wire logic [pin_state_pkg::NUM_PINS-1:0] o_pin_out,
   input wire logic [pin_state_pkg::NUM_PINS-1:0] o_pin_oe_n
);
   import pin_state_pkg::*;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////////////////////////////////
   a_bus_answer: assert property ((i_avs_read || i_avs_write)
      && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("late");
   a_one_answer: assert property (!o_avs_waitrequest
      |=> o_avs_waitrequest) else $error("answer too long");
   a_reserved_zero: assert property (
      o_avs_readdata[31:22] == 10'h000) else $error("reserved set");
   a_write_drive: assert property (i_avs_write && !o_avs_waitrequest
      && i_avs_address == 4'h0 && i_avs_byteenable[1] && i_pin_dir_out[8]
      && !i_display_enable |=> o_pin_out[8] == $past(i_avs_writedata[8])
      && !o_pin_oe_n[8]) else $error("pixel pin not driven");
   a_display_owns: assert property (i_display_enable
      |=> &o_pin_oe_n[11:0]) else $error("display pin driven");
   a_port1_owns: assert property (i_port1_tx_enable
      |=> o_pin_oe_n[12]) else $error("port 1 pin driven");
   a_port1_gpio: assert property (i_pin_dir_out[12]
      && !i_port1_tx_enable |=> !o_pin_oe_n[12]) else $error("not driven");
   a_input_float: assert property (1'b1
      |=> &(o_pin_oe_n | $past(i_pin_dir_out))) else $error("input driven");
   a_undriven_low: assert property (
      (o_pin_out & o_pin_oe_n) == 22'h0) else $error("value leaks");
   c_write: cover property (i_avs_write && !o_avs_waitrequest);
   c_read: cover property (i_avs_read && !o_avs_waitrequest);
   c_pixel: cover property (!o_pin_oe_n[8]);
endmodule
bind peripheral_pin_state_gpio pin_state_checker chk_u (.*);
`default_nettype wire

// [bench/peripheral_pin_state_gpio_tb.sv]
// Purpose: self-checking bench for the pin state block
// Assumes: partner model stands for the outside drivers
// Notes: sampler waits cover the 3 to 4 edge latency
`timescale 1ns/1ns
`default_nettype none
module peripheral_pin_state_gpio_tb;
   import pin_state_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'h0;
   logic [31:0] rdata;
   logic wreq;
   logic [NUM_PINS-1:0] dir = 22'h0;
   logic [NUM_OWNERS-1:0] en = 10'h0;
   logic [NUM_PINS-1:0] ext = 22'h0;
   logic [NUM_PINS-1:0] level;
   logic [NUM_PINS-1:0] pin_out;
   logic [NUM_PINS-1:0] oe_n;
   logic [31:0] q;
   int n_mismatch = 0;
   int cmp_count = 0;
   peripheral_pin_state_gpio dut_u (.i_clk(clk), .i_rst(rst),
      .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wdata), .i_avs_byteenable(be),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
      .i_pin_dir_out(dir), .i_display_enable(en[0]),
      .i_port1_tx_enable(en[1]), .i_port1_rx_enable(en[2]),
      .i_port2_tx_enable(en[3]), .i_port2_rx_enable(en[4]),
      .i_port3_tx_enable(en[5]), .i_port3_rx_enable(en[6]),
      .i_port4_tx_enable(en[7]), .i_port4_rx_enable(en[8]),
      .i_port4_enable(en[9]), .i_pin_in(level), .o_pin_out(pin_out),
      .o_pin_oe_n(oe_n));
   pin_partner far_u (.i_drv(pin_out), .i_oe_n(oe_n), .i_ext(ext),
      .o_level(level));
   initial forever #50 clk = ~clk;
   ////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // waitrequest is read as the rising edge samples it; one edge follows
   // the release so a second call never re-assigns within one step
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d, input logic [3:0] b, output logic [31:0] r);
      int n;
      n = 0;
      addr <= a;
      wdata <= d;
      be <= b;
      wr <= w;
      rd <= !w;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wreq !== 1'b0 && n < 50);
      if (n >= 50)
      begin
         n_mismatch++;
         final_report();
      end
      r = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic settle;
      repeat (6) @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic sc_read_levels;
      en <= 10'h3ff;
      for (int i = 0; i < 2; i++)
      begin
         ext <= i ? 22'h2a_5c3f : 22'h15_a3c0;
         settle();
         bus(1'b0, 4'h0, 32'h0, 4'hf, q);
         check("levels", q, {10'h000, ext});
      end
      bus(1'b0, 4'h4, 32'h0, 4'hf, q);
      check("unmapped", q, 32'h0);
   endtask
   task automatic sc_drive;
      // port 2 polarity stays non-inverted; no control reaches it here
      en <= 10'h000;
      bus(1'b1, 4'h0, 32'hffd5_a3c0, 4'hf, q);
      dir <= 22'h3f_ffff;
      ext <= 22'h2a_5c3f;
      settle();
      check("oe_n", oe_n, 32'h0);
      check("pin_out", pin_out, 22'h15_a3c0);
      bus(1'b0, 4'h0, 32'h0, 4'hf, q);
      check("driven", q, 32'h0015_a3c0);
      bus(1'b1, 4'h0, 32'h0000_ffff, 4'h2, q);
      bus(1'b1, 4'h4, 32'h0, 4'hf, q);
      check("lanes", pin_out, 22'h15_ffc0);
   endtask
   task automatic sc_owners;
      logic [21:0] m;
      for (int k = 0; k < 10; k++)
      begin
         m = k == 0 ? 22'hfff : k == 9 ? 22'h30_0000 : 22'h1 << (11 + k);
         en <= 10'h1 << k;
         repeat (2) @(posedge clk);
         check("owned oe_n", oe_n, m);
         check("owned out", pin_out, 22'h15_ffc0 & ~m);
      end
   endtask
   task automatic sc_owned_write;
      en <= 10'h001;
      bus(1'b1, 4'h0, 32'h0000_0f0f, 4'hf, q);
      check("owned write", pin_out, 22'h0);
      en <= 10'h000;
      repeat (2) @(posedge clk);
      check("later drive", pin_out, 22'h0f0f);
   endtask
   task automatic sc_reset;
      rst <= 1'b1;
      @(posedge clk);
      check("reset oe_n", oe_n, 22'h3f_ffff);
      rst <= 1'b0;
      settle();
      check("kept", pin_out, 22'h0f0f);
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      sc_read_levels();
      sc_drive();
      sc_owners();
      sc_owned_write();
      sc_reset();
      final_report();
   end
endmodule
`default_nettype wire
